// ### logic/charger_ctrl.sv
/*
  charger control: phase machine, expiry timers, safe mode, indicator pin,
  battery detection, and the AHB-Lite register slave.
  assumes analog comparator flags synchronous to hclk and a single slave bus.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
module charger_ctrl
  import charger_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire analog_status_s analog,
  output current_sel_e        current_sel,
  output logic [3:0]          current_code,
  output logic [1:0]          target_code,
  output charge_state_e       charge_phase,
  input  wire logic           led_in,
  output logic                led_out,
  output logic                led_oe_n,
  output logic                det_pulse,
  output logic                irq
);
  if (TICK_CYCLES_P < 2)
  begin : g_bad
    $error("tick period too short");
  end

  logic [7:0]     chg_ctrl_r;
  logic [7:0]     led_ctrl_r;
  logic [7:0]     tmr_cfg_r;
  logic           wr_pend_r;
  logic [7:0]     wr_idx_r;
  logic [7:0]     rd_byte;
  logic           acc;
  logic           mapped;
  logic [7:0]     idx;
  charge_state_e  state_r;
  charge_state_e  state_nxt;
  logic [15:0]    timer_r;
  logic [15:0]    limit;
  logic           expired;
  logic           tick;
  logic [4:0]     sub_r;
  logic           sec_tick;
  logic [3:0]     det_sec_r;
  logic           present_r;
  logic           det_fire;
  logic [BLINK_LANES-1:0] blink;
  logic           drive_low;
  logic           charging;
  logic           alarm;
  logic           ch_en;
  logic           power_ok;

  // bus slave: zero wait states, always OKAY
  assign idx    = haddr[9:2];
  assign acc    = hsel && hready && htrans[1] && (hsize == 3'b010);
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);

  always_comb
  begin
    rd_byte = 8'h00;
    if (mapped)
    begin
      case (idx)
        IDX_STATUS:
        begin
          rd_byte[ST_PIN_BIT]     = led_in;
          rd_byte[ST_SAFE_BIT]    = (state_r == ST_SAFE);
          rd_byte[ST_PRESENT_BIT] = present_r;
        end
        IDX_LED:   rd_byte = led_ctrl_r & 8'h78;
        IDX_CHG:   rd_byte = chg_ctrl_r & 8'hef;
        IDX_TIMER: rd_byte = tmr_cfg_r & 8'hd3;
        default:   rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= acc && hwrite && mapped;
      wr_idx_r  <= idx;
      if (acc && !hwrite)
      begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chg_ctrl_r <= CHG_RST;
      led_ctrl_r <= LED_RST;
      tmr_cfg_r  <= TIMER_RST;
    end
    else if (wr_pend_r)
    begin
      case (wr_idx_r)
        IDX_CHG:   chg_ctrl_r <= hwdata[7:0] & 8'hef;
        IDX_LED:   led_ctrl_r <= hwdata[7:0] & 8'h78;
        IDX_TIMER: tmr_cfg_r  <= hwdata[7:0] & 8'hd3;
        default:   chg_ctrl_r <= chg_ctrl_r;
      endcase
    end
  end

  // time base
  tick_prescaler #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sub_r <= 5'h00;
    end
    else if (tick)
    begin
      sub_r <= sub_r + 5'h01;
    end
  end

  assign sec_tick = tick && (sub_r[3:0] == 4'(TICKS_PER_SEC - 1));

  // phase machine
  assign ch_en    = chg_ctrl_r[CHG_EN_BIT];
  assign power_ok = analog.vbus_present && ch_en;

  always_comb
  begin
    if (state_r == ST_PRECHARGE)
    begin
      limit = 16'((PRE_BASE_MIN + PRE_STEP_MIN * int'(tmr_cfg_r[TMR_PRE_LSB +: 2]))
                  * SEC_PER_MIN);
    end
    else
    begin
      limit = 16'((FAST_BASE_H + FAST_STEP_H * int'(tmr_cfg_r[TMR_FAST_LSB +: 2]))
                  * SEC_PER_HOUR);
    end
  end

  // held seconds do not count toward expiry
  assign expired = sec_tick && !analog.ichg_below_fifth && (timer_r == limit - 16'h0001);

  always_comb
  begin
    state_nxt = state_r;
    if (!power_ok)
    begin
      state_nxt = ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (analog.vbat_below_restart)
          begin
            state_nxt = analog.vbat_below_precharge ? ST_PRECHARGE : ST_CONST_CUR;
          end
        end
        ST_PRECHARGE:
        begin
          if (expired)
          begin
            state_nxt = ST_SAFE;
          end
          else if (!analog.vbat_below_precharge)
          begin
            state_nxt = ST_CONST_CUR;
          end
        end
        ST_CONST_CUR:
        begin
          if (expired)
          begin
            state_nxt = ST_SAFE;
          end
          else if (analog.vbat_at_target)
          begin
            state_nxt = ST_CONST_VOLT;
          end
        end
        ST_CONST_VOLT:
        begin
          if (expired)
          begin
            state_nxt = ST_SAFE;
          end
          else if (!analog.vbat_below_restart && analog.ichg_below_tenth)
          begin
            state_nxt = ST_DONE;
          end
          else if (!analog.vbat_at_target)
          begin
            state_nxt = ST_CONST_CUR;
          end
        end
        ST_SAFE:  state_nxt = ST_SAFE;
        ST_DONE:
        begin
          if (analog.vbat_below_restart)
          begin
            state_nxt = ST_IDLE;
          end
        end
        default:  state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // expiry timer: cleared on each phase change, held on low current
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_r <= 16'h0000;
    end
    else if (state_nxt != state_r)
    begin
      timer_r <= 16'h0000;
    end
    else if (sec_tick && !analog.ichg_below_fifth)
    begin
      timer_r <= timer_r + 16'h0001;
    end
  end

  // current selection toward the analog loop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      current_sel  <= CUR_OFF;
      current_code <= 4'h0;
      target_code  <= 2'b00;
      charge_phase <= ST_IDLE;
    end
    else
    begin
      current_code <= chg_ctrl_r[CHG_CUR_LSB +: 4];
      target_code  <= chg_ctrl_r[CHG_TGT_LSB +: 2];
      charge_phase <= state_r;
      case (state_r)
        ST_PRECHARGE: current_sel <= CUR_PRECHARGE;
        ST_CONST_CUR:  current_sel <= CUR_PROGRAMMED;
        ST_CONST_VOLT: current_sel <= CUR_PROGRAMMED;
        ST_SAFE:      current_sel <= analog.vbat_below_restart ? CUR_SAFE : CUR_OFF;
        default:      current_sel <= CUR_OFF;
      endcase
    end
  end

  // battery detection
  assign det_fire = led_ctrl_r[LED_DET_EN_BIT] && analog.vbus_present && sec_tick
                    && (det_sec_r == 4'(DETECT_PERIOD_S - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      det_sec_r <= 4'h0;
      det_pulse <= 1'b0;
      present_r <= 1'b0;
    end
    else
    begin
      det_pulse <= det_fire;
      if (!analog.vbus_present || !led_ctrl_r[LED_DET_EN_BIT])
      begin
        det_sec_r <= 4'h0;
      end
      else if (sec_tick)
      begin
        det_sec_r <= det_sec_r + 4'h1;
      end
      // with detection enabled and no charger, the comparator is watched every cycle
      if (led_ctrl_r[LED_DET_EN_BIT] && (det_fire || !analog.vbus_present))
      begin
        present_r <= analog.vbat_above_presence;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= ((state_r == ST_SAFE) && (state_nxt != ST_SAFE))
             || (led_ctrl_r[LED_DET_EN_BIT] && (det_fire || !analog.vbus_present)
                 && (analog.vbat_above_presence != present_r));
    end
  end

  // indicator pin, open drain: only ever pulls low
  for (genvar i = 0; i < BLINK_LANES; i++)
  begin : g_blink
    blink_gen #(
      .LOG2 (BLINK_4HZ_LOG2 + i)
    ) u_blink (
      .tick_cnt (sub_r),
      .low      (blink[i])
    );
  end

  assign charging = (state_r == ST_PRECHARGE) || (state_r == ST_CONST_CUR)
                    || (state_r == ST_CONST_VOLT);
  assign alarm    = (state_r == ST_SAFE) || analog.die_over_level2 || analog.bat_ovp_uvp;

  always_comb
  begin
    drive_low = 1'b0;
    if (!led_ctrl_r[LED_SRC_BIT])
    begin
      case (led_ctrl_r[LED_PAT_LSB +: 2])
        2'b01:   drive_low = blink[3];
        2'b10:   drive_low = blink[1];
        2'b11:   drive_low = 1'b1;
        default: drive_low = 1'b0;
      endcase
    end
    else if (!tmr_cfg_r[TMR_STYLE_BIT])
    begin
      if (analog.vbus_over_6v3)
        drive_low = blink[0];
      else if (alarm)
        drive_low = blink[2];
      else
        drive_low = charging;
    end
    else
    begin
      if (analog.vbus_over_6v3 || alarm)
        drive_low = blink[0];
      else if (!analog.vbus_present || analog.source_insufficient)
        drive_low = 1'b0;
      else if (state_r == ST_DONE)
        drive_low = 1'b1;
      else
        drive_low = charging && blink[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_oe_n <= 1'b1;
      led_out  <= 1'b0;
    end
    else
    begin
      led_oe_n <= !drive_low;
      led_out  <= 1'b0;
    end
  end

  // checks
  sequence s_left_safe;
    (state_r == ST_SAFE) ##1 (state_r != ST_SAFE);
  endsequence

  sequence s_start;
    (state_r == ST_IDLE) ##1 (state_r == ST_PRECHARGE || state_r == ST_CONST_CUR);
  endsequence

  a_precharge_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_PRECHARGE) && power_ok && !expired && !analog.vbat_below_precharge
    |=> (state_r == ST_CONST_CUR))
    else $error("precharge did not move to constant current");

  a_precharge_current: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_PRECHARGE) ##1 (state_r == ST_PRECHARGE)
    |-> (current_sel == CUR_PRECHARGE))
    else $error("precharge current not selected");

  a_volt_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_CONST_CUR) && power_ok && !expired && analog.vbat_at_target
    |=> (state_r == ST_CONST_VOLT))
    else $error("constant voltage not entered at target");

  a_start_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    s_start |-> $past(power_ok) && $past(analog.vbat_below_restart))
    else $error("charge started without its conditions");

  a_terminate: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_CONST_VOLT) && power_ok && !expired && !analog.vbat_below_restart
    && analog.ichg_below_tenth |=> (state_r == ST_DONE))
    else $error("charge did not terminate");

  a_timer_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_nxt == state_r) && analog.ichg_below_fifth |=> $stable(timer_r))
    else $error("expiry timer ran on low current");

  a_safe_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    s_left_safe |-> irq)
    else $error("no interrupt on leaving safe mode");

  a_power_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    !analog.vbus_present |=> (state_r == ST_IDLE))
    else $error("power loss did not end charging");

  a_manual_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !led_ctrl_r[LED_SRC_BIT] && (led_ctrl_r[LED_PAT_LSB +: 2] == 2'b11) |=> !led_oe_n)
    else $error("manual drive low not applied");

  a_presence_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (present_r != $past(present_r)) |-> irq)
    else $error("presence change without interrupt");

  a_detect_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    det_pulse |=> !det_pulse [*8])
    else $error("detection pulses too close");
endmodule

// ### logic/charger_pkg.sv
/*
  constants, field layout, types and carriers of the charger control block.
  assumes a 20 MHz hclk and analog comparators outside that report as flags.
*/
package charger_pkg;

  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_LED    = 8'h32;
  localparam logic [7:0] IDX_CHG    = 8'h33;
  localparam logic [7:0] IDX_TIMER  = 8'h34;

  localparam int CHG_EN_BIT     = 7;
  localparam int CHG_TGT_LSB    = 5;
  localparam int CHG_CUR_LSB    = 0;
  localparam int LED_DET_EN_BIT = 6;
  localparam int LED_PAT_LSB    = 4;
  localparam int LED_SRC_BIT    = 3;
  localparam int TMR_PRE_LSB    = 6;
  localparam int TMR_STYLE_BIT  = 4;
  localparam int TMR_FAST_LSB   = 0;
  localparam int ST_PIN_BIT     = 0;
  localparam int ST_SAFE_BIT    = 3;
  localparam int ST_PRESENT_BIT = 5;

  localparam logic [7:0] CHG_RST   = 8'h80;
  localparam logic [7:0] LED_RST   = 8'h40;
  localparam logic [7:0] TIMER_RST = 8'h41;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_NS         = 62_500_000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC   = 16;
  localparam int SEC_PER_MIN     = 60;
  localparam int SEC_PER_HOUR    = 3600;
  localparam int PRE_BASE_MIN    = 40;
  localparam int PRE_STEP_MIN    = 10;
  localparam int FAST_BASE_H     = 6;
  localparam int FAST_STEP_H     = 2;
  localparam int DETECT_PERIOD_S = 16;
  localparam int BLINK_4HZ_LOG2  = 2;
  localparam int BLINK_LANES     = 4;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRECHARGE, ST_CONST_CUR, ST_CONST_VOLT, ST_SAFE, ST_DONE
  } charge_state_e;

  typedef enum logic [1:0] {
    CUR_OFF, CUR_PRECHARGE, CUR_PROGRAMMED, CUR_SAFE
  } current_sel_e;

  typedef struct packed {
    logic vbus_present;
    logic vbus_over_6v3;
    logic source_insufficient;
    logic vbat_below_precharge;
    logic vbat_below_restart;
    logic vbat_at_target;
    logic vbat_above_presence;
    logic ichg_below_tenth;
    logic ichg_below_fifth;
    logic die_over_level2;
    logic bat_ovp_uvp;
  } analog_status_s;

endpackage

// ### logic/tick_prescaler.sv
/*
  divides hclk down to a one-cycle tick pulse.
  assumes a free running hclk.
*/
`timescale 1ns/100ps
module tick_prescaler #(
  parameter int unsigned CYCLES = 1250000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  localparam int W = $clog2(CYCLES);

  logic [W-1:0] cnt_r;

  if (CYCLES < 2)
  begin : g_bad
    $error("tick prescaler needs at least two cycles");
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (cnt_r == W'(CYCLES - 1));
      cnt_r <= (cnt_r == W'(CYCLES - 1)) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

// ### logic/blink_gen.sv
/*
  25% low pattern from the shared tick count; period is 2**LOG2 ticks.
  assumes tick_cnt counts ticks of 1/16 s.
*/
`timescale 1ns/100ps
module blink_gen #(
  parameter int LOG2 = 2
) (
  input  wire logic [4:0] tick_cnt,
  output logic            low
);
  if (LOG2 < 2 || LOG2 > 5)
  begin : g_bad
    $error("blink period out of range");
  end

  // low while the top two bits of the period are zero: a quarter
  assign low = (tick_cnt[LOG2-1 -: 2] == 2'b00);
endmodule

// ### bench/battery_model.sv
/*
  far side of the charger: cell, supply and indicator pin with pull-up.
  assumes the bench sets cell voltage, relative current and fault flags.
*/
`timescale 1ns/100ps
module battery_model
  import charger_pkg::*;
#(
  parameter int TGT_MV = 4200
) (
  input  wire logic         vbus,
  input  wire logic [12:0]  vbat_mv,
  input  wire logic [6:0]   pct,
  input  wire logic [2:0]   faults,
  input  wire current_sel_e current_sel,
  input  wire logic         led_out,
  input  wire logic         led_oe_n,
  output analog_status_s    analog,
  output logic              led_in
);
  logic no_cur;
  // released pin reads high through the pull-up, never the last level
  assign led_in = led_oe_n ? 1'b1 : led_out;
  assign no_cur = !vbus || current_sel == CUR_OFF;
  always_comb
  begin
    analog.vbus_present         = vbus;
    analog.vbus_over_6v3        = vbus & faults[2];
    // weak supply: charge current collapses to zero
    analog.source_insufficient  = vbus & (pct == 7'd0);
    analog.vbat_below_precharge = vbat_mv < 13'd3000;
    analog.vbat_below_restart   = vbat_mv < 13'(TGT_MV - 100);
    analog.vbat_at_target       = vbat_mv >= 13'(TGT_MV);
    analog.vbat_above_presence  = vbat_mv > 13'd2200;
    analog.ichg_below_tenth     = no_cur || pct < 7'd10;
    analog.ichg_below_fifth     = no_cur || pct < 7'd20;
    analog.die_over_level2      = faults[1];
    analog.bat_ovp_uvp          = faults[0];
  end
endmodule

// ### bench/tb_top.sv
/*
  self-checking bench of the charger control block.
  assumes the package constants and the battery model on the analog side.
*/
`timescale 1ns/100ps
module tb_top
  import charger_pkg::*;
;
  localparam int TK = 2;
  logic           hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, vbus = 1'b0;
  logic [31:0]    haddr = '0, hwdata = '0, hrdata, rs = 32'd29;
  logic [1:0]     htrans = 2'b00, tcode;
  logic [2:0]     hsize = 3'b010, faults = 3'b000;
  logic [12:0]    vbat = 13'd2500;
  logic [6:0]     pct = 7'd50;
  logic [3:0]     ccode;
  logic           hready, hreadyout, hresp, led_in, led_out, led_oe_n, det_pulse, irq;
  logic           rd_pend = 1'b0;
  analog_status_s analog;
  current_sel_e   csel;
  charge_state_e  ph;
  logic [31:0]    rq[$];
  int             failures = 0, comparisons = 0, irq_n = 0, det_n = 0, el;
  int             ml[4] = '{0, 64, 64, 256};
  int             me[4] = '{0, 4, 16, 0};

  always #25 hclk = ~hclk;
  assign hready = hreadyout;

  charger_ctrl #(.TICK_CYCLES_P(TK)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .analog(analog),
    .current_sel(csel), .current_code(ccode), .target_code(tcode), .charge_phase(ph),
    .led_in(led_in), .led_out(led_out), .led_oe_n(led_oe_n), .det_pulse(det_pulse),
    .irq(irq));

  battery_model PARTNER (
    .vbus(vbus), .vbat_mv(vbat), .pct(pct), .faults(faults), .current_sel(csel),
    .led_out(led_out), .led_oe_n(led_oe_n), .analog(analog), .led_in(led_in));

  task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
    comparisons++;
    if (a !== e)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d failures in %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tmo();
    failures++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop();
  endtask

  // read data is checked here, oldest note first, at the data-phase edge
  always @(posedge hclk)
  begin
    if (irq === 1'b1) irq_n++;
    if (det_pulse === 1'b1) det_n++;
    if (rd_pend && hreadyout === 1'b1)
    begin
      chk(hrdata, rq.pop_front(), "read");
      chk(hresp, 1'b0, "okay");
    end
    if (hreadyout === 1'b1) rd_pend = hsel && htrans[1] && !hwrite;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) tmo();
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'd0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic wph(input charge_state_e e, input int lim);
    el = 0;
    while (ph !== e && el < lim)
    begin
      @(posedge hclk);
      el++;
    end
    chk(ph, e, "phase");
    if (ph !== e) tmo();
  endtask

  task automatic wdet();
    el = 1;
    @(posedge hclk);
    while (det_pulse !== 1'b1 && el < 600)
    begin
      @(posedge hclk);
      el++;
    end
    if (det_pulse !== 1'b1) tmo();
  endtask

  // 256 cycles span whole periods of every pattern, so lows are exact
  task automatic meas(input int nl, input int ne, input string m);
    int l, f;
    logic p;
    l = 0;
    f = 0;
    repeat (8) @(posedge hclk);
    p = led_oe_n;
    repeat (256)
    begin
      @(posedge hclk);
      if (led_oe_n === 1'b0) l++;
      if (led_oe_n === 1'b0 && p === 1'b1) f++;
      p = led_oe_n;
    end
    chk(l, nl, m);
    chk(f + 1 >= ne && f <= ne + 1, 1'b1, m);
    chk(led_out, 1'b0, m);
  endtask

  initial
  begin
    logic [31:0] d;
    int t;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_TIMER, 32'h41);
    rd(IDX_LED, 32'h40);
    rd(IDX_CHG, 32'h80);
    rd(IDX_STATUS, 32'h21);
    for (int i = 0; i < 6; i++)
    begin
      d = rnd();
      wr(IDX_TIMER, d);
      rd(IDX_TIMER, d & 32'hd3);
      wr(IDX_LED, d);
      rd(IDX_LED, d & 32'h78);
    end
    wr(8'h35, d);
    rd(8'h35, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_LED, 32'(i) << 4);
      meas(ml[i], me[i], "manual");
    end
    wr(IDX_LED, 32'h48);
    wr(IDX_TIMER, 32'h41);
    wr(IDX_CHG, 32'ha5);
    vbat <= 13'd4200;
    vbus <= 1'b1;
    repeat (20) @(posedge hclk);
    chk(ph, ST_IDLE, "start above restart");
    meas(0, 0, "a idle");
    vbat <= 13'd2500;
    wph(ST_PRECHARGE, 20);
    repeat (2) @(posedge hclk);
    chk(csel, CUR_PRECHARGE, "pre cur");
    chk({tcode, ccode}, 6'h15, "codes");
    meas(256, 0, "a chg");
    faults <= 3'b100;
    meas(64, 32, "a over");
    faults <= 3'b001;
    meas(64, 8, "a ovp");
    faults <= 3'b000;
    wr(IDX_TIMER, 32'h51);
    meas(64, 8, "b chg");
    faults <= 3'b010;
    meas(64, 32, "b alarm");
    faults <= 3'b000;
    pct <= 7'd0;
    meas(0, 0, "b weak");
    pct <= 7'd50;
    vbat <= 13'd3000;
    wph(ST_CONST_CUR, 20);
    repeat (2) @(posedge hclk);
    chk(csel, CUR_PROGRAMMED, "fast cur");
    vbat <= 13'd4200;
    wph(ST_CONST_VOLT, 20);
    pct <= 7'd5;
    wph(ST_DONE, 20);
    meas(256, 0, "b full");
    wr(IDX_LED, 32'h40);
    wdet();
    wdet();
    chk(el, 16 * 16 * TK, "detect period");
    t = irq_n;
    vbat <= 13'd1000;
    wdet();
    repeat (3) @(posedge hclk);
    chk(irq_n, t + 1, "removal irq");
    rd(IDX_STATUS, 32'h01);
    vbat <= 13'd2500;
    wdet();
    repeat (3) @(posedge hclk);
    chk(irq_n, t + 2, "insert irq");
    rd(IDX_STATUS, 32'h21);
    wr(IDX_LED, 32'h08);
    t = det_n;
    repeat (600) @(posedge hclk);
    chk(det_n, t, "detect off");
    wr(IDX_TIMER, 32'h01);
    pct <= 7'd50;
    vbus <= 1'b0;
    repeat (4) @(posedge hclk);
    vbus <= 1'b1;
    wph(ST_PRECHARGE, 20);
    repeat (500) @(posedge hclk);
    pct <= 7'd15;
    repeat (1000) @(posedge hclk);
    pct <= 7'd50;
    wph(ST_SAFE, 90000);
    t = el + 1500 - (40 * 60 * 16 * TK + 1000);
    chk(t > -100 && t < 100, 1'b1, "expiry time");
    repeat (2) @(posedge hclk);
    chk(csel, CUR_SAFE, "safe cur");
    meas(64, 8, "a timeout");
    wr(IDX_LED, 32'h40);
    rd(IDX_STATUS, 32'h29);
    vbat <= 13'd4200;
    repeat (3) @(posedge hclk);
    chk(csel, CUR_OFF, "safe full");
    t = irq_n;
    wr(IDX_CHG, 32'h25);
    wph(ST_IDLE, 10);
    repeat (2) @(posedge hclk);
    chk(irq_n, t + 1, "safe exit irq");
    rd(IDX_STATUS, 32'h21);
    report_and_stop();
  end
endmodule
